// ### logic/bir_pkg.sv
// Purpose: Shared constants for the board interrupt routing pair.
// Assumes: One 100 MHz clock, asynchronous active-low reset.
// Notes: The rules carried by this block follow.
package bir_pkg;
   localparam int          BIR_NUM_IRQ     = 16;
   localparam int          BIR_NUM_PCI     = 8;
   localparam int          BIR_NUM_APIC_IN = 24;
   localparam int          BIR_SRC_W       = 5;
   localparam int          BIR_SLOTS       = 17;
   localparam int          BIR_SLOT_W      = 5;
   localparam int          BIR_CASC_LVL    = 2;
   localparam int          BIR_TIMER_LVL   = 0;
   localparam int          BIR_RTC_LVL     = 8;
   localparam int          BIR_MSG_W       = 8;
   localparam int          BIR_BIT_W       = 3;
   localparam int          BIR_LINK_DIV    = 6;
   localparam logic [2:0]  BIR_DIV_RST     = 3'h0;
   localparam logic [7:0]  BIR_VEC_RST     = 8'h00;
   localparam logic [15:0] BIR_IRQ_RST     = 16'h0000;
   localparam logic [4:0]  BIR_SLOT_RST    = 5'h00;
endpackage : bir_pkg

// ### logic/bir_if.sv
// Purpose: Link between the routing device and the processor side.
// Assumes: Both ends share MCLK; open-drain lines resolve as wired-AND.
// Notes: Low on any driver pulls the line low.
`timescale 1ns/1ps
`default_nettype none
interface bir_if;
   logic legacy_intr;
   logic nmi;
   logic apic_clk;
   logic apic_d0_dev_oe;
   logic apic_d1_dev_oe;
   logic apic_d0_cpu_oe;
   logic apic_d1_cpu_oe;
   logic serial_irq_dev_oe;
   logic serial_irq_cpu_oe;
   logic apic_d0;
   logic apic_d1;
   logic serial_irq_line;
   assign apic_d0         = ~(apic_d0_dev_oe | apic_d0_cpu_oe);
   assign apic_d1         = ~(apic_d1_dev_oe | apic_d1_cpu_oe);
   assign serial_irq_line = ~(serial_irq_dev_oe | serial_irq_cpu_oe);
   modport dev (output legacy_intr, nmi, apic_clk, apic_d0_dev_oe, apic_d1_dev_oe,
                serial_irq_dev_oe, input apic_d0, apic_d1, serial_irq_line);
   modport cpu (input legacy_intr, nmi, apic_clk, apic_d0, apic_d1, serial_irq_line,
                output apic_d0_cpu_oe, apic_d1_cpu_oe, serial_irq_cpu_oe);
endinterface : bir_if
`default_nettype wire

// ### logic/bir_device.sv
// Purpose: Device end: cascaded legacy pair, apic message sender, serial irq host.
// Assumes: Request inputs are synchronous to MCLK; link lines come from pins.
// Notes: Open-drain pins are driven low only; enable high means pulling low.
`timescale 1ns/1ps
`default_nettype none
module bir_device
   import bir_pkg::*;
(
   input  wire logic                               MCLK,
   input  wire logic                               RST_N,
   input  wire logic [BIR_NUM_IRQ-1:0]             IRQ_REQ,
   input  wire logic [BIR_NUM_PCI-1:0]             PCI_INT,
   input  wire logic                               PCI_PERR,
   input  wire logic                               PCI_SERR,
   input  wire logic                               SERR_NMI_EN,
   input  wire logic                               APIC_MODE,
   input  wire logic                               SIRQ_CONT,
   input  wire logic [BIR_NUM_APIC_IN*BIR_SRC_W-1:0] APIC_MAP,
   output logic                                    CASCADE_OUT,
   output logic                                    BUSY,
   bir_if.dev                                      lnk
);
   typedef enum logic [3:0] {
      BIR_S_IDLE  = 4'b0001,
      BIR_S_START = 4'b0010,
      BIR_S_SLOT  = 4'b0100,
      BIR_S_STOP  = 4'b1000
   } bir_sirq_e;

   // Synchronised link inputs; only the second stage is read.
   logic [2:0] meta_q;
   logic [2:0] sync_q;
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         meta_q <= 3'h7;
         sync_q <= 3'h7;
      end else begin
         meta_q <= {lnk.serial_irq_line, lnk.apic_d1, lnk.apic_d0};
         sync_q <= meta_q;
      end
   end

   // Legacy pair: 15 external levels, timer included, plus cascade fed internally.
   logic [BIR_NUM_IRQ-1:0] lvl;
   logic [BIR_NUM_IRQ-1:0] sirq_lvl_q;
   logic [BIR_NUM_IRQ-1:0] sirq_lvl_d;
   logic                   sec_any;
   logic                   prim_any;
   always_comb begin
      lvl                = IRQ_REQ | sirq_lvl_q;
      lvl[BIR_RTC_LVL]   = ~IRQ_REQ[BIR_RTC_LVL] | sirq_lvl_q[BIR_RTC_LVL];
      sec_any            = |lvl[15:8];
      lvl[BIR_CASC_LVL]  = sec_any;
      prim_any           = |lvl[7:0];
   end

   // NMI, legacy output and cascade indication are registered outputs.
   logic nmi_q;
   logic nmi_d;
   logic intr_q;
   logic intr_d;
   logic casc_q;
   logic casc_d;
   always_comb begin
      nmi_d  = PCI_SERR & SERR_NMI_EN;
      intr_d = ~APIC_MODE & prim_any;
      casc_d = sec_any;
   end
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         nmi_q  <= 1'b0;
         intr_q <= 1'b0;
         casc_q <= 1'b0;
      end else begin
         nmi_q  <= nmi_d;
         intr_q <= intr_d;
         casc_q <= casc_d;
      end
   end
   assign lnk.nmi     = nmi_q;
   assign lnk.legacy_intr = intr_q;
   assign CASCADE_OUT = casc_q;

   // Apic inputs: each selects one of 16 irq or 8 pci sources.
   logic [BIR_NUM_IRQ+BIR_NUM_PCI-1:0] srcs;
   logic [BIR_NUM_APIC_IN-1:0]         pin;
   logic [BIR_NUM_APIC_IN-1:0]         pin_q;
   logic [BIR_NUM_APIC_IN-1:0]         pend_q;
   logic [BIR_NUM_APIC_IN-1:0]         pend_d;
   always_comb begin
      srcs = {PCI_INT, lvl};
      for (int i = 0; i < BIR_NUM_APIC_IN; i++) begin
         pin[i] = srcs[APIC_MAP[i*BIR_SRC_W +: BIR_SRC_W]];
      end
   end

   // Apic sender: divided link clock, one message byte on two lines.
   logic [2:0]           div_q;
   logic [2:0]           div_d;
   logic                 aclk_q;
   logic                 aclk_d;
   logic                 busy_q;
   logic                 busy_d;
   logic [BIR_BIT_W-1:0] bit_q;
   logic [BIR_BIT_W-1:0] bit_d;
   logic [BIR_MSG_W-1:0] msg_q;
   logic [BIR_MSG_W-1:0] msg_d;
   logic                 d0_q;
   logic                 d0_d;
   logic                 d1_q;
   logic                 d1_d;
   logic                 tick;
   logic [BIR_MSG_W-1:0] pick;
   logic                 found;
   always_comb begin
      tick   = (div_q == 3'(BIR_LINK_DIV - 1));
      div_d  = tick ? BIR_DIV_RST : div_q + 3'h1;
      aclk_d = tick ? ~aclk_q : aclk_q;
      // Edges outside apic mode are dropped so that stale requests are never sent later.
      pend_d = pend_q | (pin & ~pin_q & {BIR_NUM_APIC_IN{APIC_MODE}});
      busy_d = busy_q;
      bit_d  = bit_q;
      msg_d  = msg_q;
      d0_d   = d0_q;
      d1_d   = d1_q;
      pick   = BIR_VEC_RST;
      found  = 1'b0;
      for (int i = BIR_NUM_APIC_IN - 1; i >= 0; i--) begin
         if (pend_q[i]) begin
            pick  = 8'(i);
            found = 1'b1;
         end
      end
      if (tick && aclk_q) begin
         // Data changes on the falling edge so the receiver samples on rising.
         if (!busy_q && found && APIC_MODE) begin
            busy_d       = 1'b1;
            msg_d        = pick;
            bit_d        = '0;
            pend_d[pick[4:0]] = 1'b0;
            d0_d         = 1'b1;
            d1_d         = 1'b1;
         end else if (busy_q) begin
            d0_d  = ~msg_q[2*bit_q[1:0]];
            d1_d  = ~msg_q[2*bit_q[1:0]+1];
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h4) begin
               busy_d = 1'b0;
               d0_d   = 1'b0;
               d1_d   = 1'b0;
            end
         end
      end
   end
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         div_q  <= BIR_DIV_RST;
         aclk_q <= 1'b0;
         busy_q <= 1'b0;
         bit_q  <= '0;
         msg_q  <= BIR_VEC_RST;
         d0_q   <= 1'b0;
         d1_q   <= 1'b0;
         pin_q  <= '0;
         pend_q <= '0;
      end else begin
         div_q  <= div_d;
         aclk_q <= aclk_d;
         busy_q <= busy_d;
         bit_q  <= bit_d;
         msg_q  <= msg_d;
         d0_q   <= d0_d;
         d1_q   <= d1_d;
         pin_q  <= pin;
         pend_q <= pend_d;
      end
   end
   assign lnk.apic_clk       = aclk_q;
   assign lnk.apic_d0_dev_oe = d0_q;
   assign lnk.apic_d1_dev_oe = d1_q;
   assign BUSY               = busy_q;

   // Serial irq host: one frame step per link tick.
   bir_sirq_e            st_q;
   bir_sirq_e            st_d;
   logic [BIR_SLOT_W-1:0] slot_q;
   logic [BIR_SLOT_W-1:0] slot_d;
   logic                 soe_q;
   logic                 soe_d;
   always_comb begin
      st_d       = st_q;
      slot_d     = slot_q;
      soe_d      = 1'b0;
      sirq_lvl_d = sirq_lvl_q;
      unique case (st_q)
         BIR_S_IDLE: begin
            // Quiet mode lets a slave pull the line to request a frame.
            if (tick && (SIRQ_CONT || !sync_q[2])) begin
               st_d  = BIR_S_START;
               soe_d = 1'b1;
            end
         end
         BIR_S_START: begin
            soe_d = 1'b1;
            if (tick) begin
               st_d   = BIR_S_SLOT;
               soe_d  = 1'b0;
               slot_d = BIR_SLOT_RST;
            end
         end
         BIR_S_SLOT: begin
            if (tick) begin
               if (slot_q < 5'(BIR_NUM_IRQ)) begin
                  sirq_lvl_d[slot_q[3:0]] = ~sync_q[2];
               end
               slot_d = slot_q + 5'h01;
               if (slot_q == 5'(BIR_SLOTS - 1)) begin
                  st_d  = BIR_S_STOP;
                  soe_d = 1'b1;
               end
            end
         end
         BIR_S_STOP: begin
            soe_d = 1'b1;
            if (tick) begin
               st_d  = BIR_S_IDLE;
               soe_d = 1'b0;
            end
         end
      endcase
   end
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         st_q       <= BIR_S_IDLE;
         slot_q     <= BIR_SLOT_RST;
         soe_q      <= 1'b0;
         sirq_lvl_q <= BIR_IRQ_RST;
      end else begin
         st_q       <= st_d;
         slot_q     <= slot_d;
         soe_q      <= soe_d;
         sirq_lvl_q <= sirq_lvl_d;
      end
   end
   assign lnk.serial_irq_dev_oe = soe_q;
endmodule : bir_device
`default_nettype wire

// ### logic/bir_cpu.sv
// Purpose: Processor end: takes legacy interrupt, receives apic messages, raises slave irqs.
// Assumes: Link lines arrive from pins and are synchronised here.
// Notes: Only the processor with SERVICER high acknowledges legacy interrupts.
`timescale 1ns/1ps
`default_nettype none
module bir_cpu
   import bir_pkg::*;
(
   input  wire logic                 MCLK,
   input  wire logic                 RST_N,
   input  wire logic                 SERVICER,
   input  wire logic                 SLAVE_REQ,
   input  wire logic                 PERR_SEEN,
   input  wire logic                 RETRY_OK,
   output logic                      TAKE_INTR,
   output logic                      NMI_SEEN,
   output logic                      MSG_VALID,
   output logic [BIR_MSG_W-1:0]      MSG_VEC,
   output logic                      RETRY,
   output logic                      SERR_OUT,
   bir_if.cpu                        lnk
);
   logic [5:0] meta_q;
   logic [5:0] sync_q;
   logic       aclk_old_q;
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         meta_q     <= 6'h1C;
         sync_q     <= 6'h1C;
         aclk_old_q <= 1'b0;
      end else begin
         meta_q     <= {lnk.nmi, lnk.serial_irq_line, lnk.apic_d1, lnk.apic_d0,
                        lnk.apic_clk, lnk.legacy_intr};
         sync_q     <= meta_q;
         aclk_old_q <= sync_q[1];
      end
   end

   logic                 rise;
   logic                 act_q;
   logic                 act_d;
   logic [BIR_BIT_W-1:0] bit_q;
   logic [BIR_BIT_W-1:0] bit_d;
   logic [BIR_MSG_W-1:0] sh_q;
   logic [BIR_MSG_W-1:0] sh_d;
   logic                 mv_q;
   logic                 mv_d;
   logic [BIR_MSG_W-1:0] vec_q;
   logic [BIR_MSG_W-1:0] vec_d;
   logic                 tk_q;
   logic                 tk_d;
   logic                 nmi_q;
   logic                 nmi_d;
   logic                 rt_q;
   logic                 rt_d;
   logic                 se_q;
   logic                 se_d;
   logic                 soe_q;
   logic                 soe_d;
   logic                 sl_old_q;
   logic [2:0]           pull_q;
   logic [2:0]           pull_d;
   always_comb begin
      rise  = sync_q[1] & ~aclk_old_q;
      act_d = act_q;
      bit_d = bit_q;
      sh_d  = sh_q;
      mv_d  = 1'b0;
      vec_d = vec_q;
      if (rise) begin
         if (!act_q && !sync_q[2] && !sync_q[3]) begin
            act_d = 1'b1;
            bit_d = '0;
         end else if (act_q) begin
            sh_d[2*bit_q[1:0]]   = sync_q[2];
            sh_d[2*bit_q[1:0]+1] = sync_q[3];
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h3) begin
               act_d = 1'b0;
               mv_d  = 1'b1;
               vec_d = sh_d;
            end
         end
      end
      tk_d  = sync_q[0] & SERVICER;
      nmi_d = sync_q[5];
      rt_d  = PERR_SEEN & RETRY_OK;
      se_d  = PERR_SEEN & ~RETRY_OK;
      // The pull lasts a whole frame step, so the host's slower tick cannot miss it.
      pull_d = pull_q;
      if (pull_q != 3'h0) begin
         pull_d = pull_q - 3'h1;
      end else if (SLAVE_REQ && !sl_old_q && sync_q[4]) begin
         pull_d = 3'(BIR_LINK_DIV);
      end
      soe_d = (pull_d != 3'h0);
   end
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         act_q    <= 1'b0;
         bit_q    <= '0;
         sh_q     <= BIR_VEC_RST;
         mv_q     <= 1'b0;
         vec_q    <= BIR_VEC_RST;
         tk_q     <= 1'b0;
         nmi_q    <= 1'b0;
         rt_q     <= 1'b0;
         se_q     <= 1'b0;
         soe_q    <= 1'b0;
         sl_old_q <= 1'b0;
         pull_q   <= 3'h0;
      end else begin
         act_q    <= act_d;
         bit_q    <= bit_d;
         sh_q     <= sh_d;
         mv_q     <= mv_d;
         vec_q    <= vec_d;
         tk_q     <= tk_d;
         nmi_q    <= nmi_d;
         rt_q     <= rt_d;
         se_q     <= se_d;
         soe_q    <= soe_d;
         sl_old_q <= SLAVE_REQ;
         pull_q   <= pull_d;
      end
   end
   assign TAKE_INTR             = tk_q;
   assign NMI_SEEN              = nmi_q;
   assign MSG_VALID             = mv_q;
   assign MSG_VEC               = vec_q;
   assign RETRY                 = rt_q;
   assign SERR_OUT              = se_q;
   assign lnk.apic_d0_cpu_oe    = 1'b0;
   assign lnk.apic_d1_cpu_oe    = 1'b0;
   assign lnk.serial_irq_cpu_oe = soe_q;
endmodule : bir_cpu
`default_nettype wire

// ### dv/bir_routing_sva.sv
// Purpose: Checker on the link that joins the routing device to the processor end.
// Assumes: One clock domain, asynchronous active-low reset, six-cycle serial ticks.
// Notes: Device inputs are watched beside the link so outputs can be tied to causes.
`timescale 1ns/1ps
`default_nettype none
module bir_routing_sva
   import bir_pkg::*;
(
   input wire logic                   MCLK,
   input wire logic                   RST_N,
   input wire logic                   PCI_SERR,
   input wire logic                   SERR_NMI_EN,
   input wire logic                   APIC_MODE,
   input wire logic [BIR_NUM_IRQ-1:0] IRQ_REQ,
   input wire logic                   legacy_intr,
   input wire logic                   nmi,
   input wire logic                   apic_clk,
   input wire logic                   apic_d0_dev_oe,
   input wire logic                   apic_d1_dev_oe,
   input wire logic                   serial_irq_dev_oe
);
   localparam int SLOT_GAP = 102;
   logic [15:0] gap_q, gap_d;
   logic        in_frame_q, in_frame_d, oe_q, oe_d;

   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_N);

   // Low cycles are counted so the slot run between start and stop can be measured.
   always_comb begin
      gap_d      = serial_irq_dev_oe ? 16'h0000 : gap_q + 16'h0001;
      oe_d       = serial_irq_dev_oe;
      in_frame_d = in_frame_q ^ (oe_q & ~serial_irq_dev_oe);
   end
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         gap_q      <= 16'h0000;
         oe_q       <= 1'b0;
         in_frame_q <= 1'b0;
      end else begin
         gap_q      <= gap_d;
         oe_q       <= oe_d;
         in_frame_q <= in_frame_d;
      end
   end

   property p_timer; !APIC_MODE && IRQ_REQ[0] |=> legacy_intr; endproperty
   a_timer: assert property (p_timer) else $error("timer request not presented");
   property p_rtc; !APIC_MODE && !IRQ_REQ[8] |=> legacy_intr; endproperty
   a_rtc: assert property (p_rtc) else $error("low clock request not presented");
   property p_cascade; !APIC_MODE && (|IRQ_REQ[15:9]) |=> legacy_intr; endproperty
   a_cascade: assert property (p_cascade) else $error("upper level lost");
   property p_apic_quiet; APIC_MODE |=> !legacy_intr; endproperty
   a_apic_quiet: assert property (p_apic_quiet) else $error("legacy in apic mode");
   property p_nmi_on; PCI_SERR && SERR_NMI_EN |=> nmi; endproperty
   a_nmi_on: assert property (p_nmi_on) else $error("system error not forwarded");
   property p_nmi_off; !SERR_NMI_EN |=> !nmi; endproperty
   a_nmi_off: assert property (p_nmi_off) else $error("nmi while disabled");
   property p_apic_clk; $rose(apic_clk) |-> apic_clk [*6] ##1 !apic_clk; endproperty
   a_apic_clk: assert property (p_apic_clk) else $error("apic clock high phase");
   property p_apic_data;
      apic_clk && $past(apic_clk) |-> $stable(apic_d0_dev_oe) && $stable(apic_d1_dev_oe);
   endproperty
   a_apic_data: assert property (p_apic_data) else $error("apic data moved");
   property p_sirq_pulse;
      $rose(serial_irq_dev_oe) |-> serial_irq_dev_oe [*6] ##1 !serial_irq_dev_oe;
   endproperty
   a_sirq_pulse: assert property (p_sirq_pulse) else $error("frame pulse length");
   property p_sirq_slots; $rose(serial_irq_dev_oe) && in_frame_q |-> gap_q >= SLOT_GAP; endproperty
   a_sirq_slots: assert property (p_sirq_slots) else $error("too few slots");

   c_nmi:   cover property ($rose(nmi));
   c_apic:  cover property ($rose(apic_d0_dev_oe) && apic_d1_dev_oe);
   c_frame: cover property ($rose(serial_irq_dev_oe) && in_frame_q);
endmodule : bir_routing_sva
`default_nettype wire

// ### dv/board_interrupt_routing_tb.sv
// Purpose: Self-checking bench joining the device end and the processor end.
// Assumes: Inputs change 1 ns after the rising edge; seeded random choices.
// Notes: Apic pins rest on source 15, which is raised only in the legacy pass, so only one pin fires.
`timescale 1ns/1ps
`default_nettype none
`define BIR_CHK(a, e, m) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
   $display("ERROR %0t %s", $time, m); end end
module board_interrupt_routing_tb
   import bir_pkg::*;
;
   logic        MCLK, RST_N, PCI_PERR, PCI_SERR, SERR_NMI_EN, APIC_MODE, SIRQ_CONT;
   logic        SERVICER, SLAVE_REQ, PERR_SEEN, RETRY_OK, CASCADE_OUT, BUSY;
   logic        TAKE_INTR, NMI_SEEN, MSG_VALID, RETRY, SERR_OUT;
   logic [15:0] IRQ_REQ;
   logic [7:0]  PCI_INT, MSG_VEC;
   logic [BIR_NUM_APIC_IN*BIR_SRC_W-1:0] APIC_MAP;
   logic [4:0]  src;
   int          bad_count, num_checks, cycles, seed, i, k, n, r, pin;

   bir_if i_bir_if ();
   bir_device i_bir_device (.MCLK(MCLK), .RST_N(RST_N), .IRQ_REQ(IRQ_REQ), .PCI_INT(PCI_INT),
      .PCI_PERR(PCI_PERR), .PCI_SERR(PCI_SERR), .SERR_NMI_EN(SERR_NMI_EN),
      .APIC_MODE(APIC_MODE), .SIRQ_CONT(SIRQ_CONT), .APIC_MAP(APIC_MAP),
      .CASCADE_OUT(CASCADE_OUT), .BUSY(BUSY), .lnk(i_bir_if));
   bir_cpu i_bir_cpu (.MCLK(MCLK), .RST_N(RST_N), .SERVICER(SERVICER), .SLAVE_REQ(SLAVE_REQ),
      .PERR_SEEN(PERR_SEEN), .RETRY_OK(RETRY_OK), .TAKE_INTR(TAKE_INTR), .NMI_SEEN(NMI_SEEN),
      .MSG_VALID(MSG_VALID), .MSG_VEC(MSG_VEC), .RETRY(RETRY), .SERR_OUT(SERR_OUT),
      .lnk(i_bir_if));
   bir_routing_sva i_bir_routing_sva (.MCLK(MCLK), .RST_N(RST_N), .PCI_SERR(PCI_SERR),
      .SERR_NMI_EN(SERR_NMI_EN), .APIC_MODE(APIC_MODE), .IRQ_REQ(IRQ_REQ),
      .legacy_intr(i_bir_if.legacy_intr), .nmi(i_bir_if.nmi), .apic_clk(i_bir_if.apic_clk),
      .apic_d0_dev_oe(i_bir_if.apic_d0_dev_oe), .apic_d1_dev_oe(i_bir_if.apic_d1_dev_oe),
      .serial_irq_dev_oe(i_bir_if.serial_irq_dev_oe));

   // Level l active, all others idle; the clock interrupt on level 8 is active low.
   function automatic logic [15:0] act(input int l);
      return 16'h0100 ^ (16'h0001 << l);
   endfunction : act
   function automatic logic exp_legacy(input int l);
      return l != BIR_CASC_LVL;
   endfunction : exp_legacy

   task tick(input int c);
      repeat (c) @(posedge MCLK);
      #1;
   endtask : tick
   task count_rises(input int c, output int rises);
      logic p;
      rises = 0;
      p = i_bir_if.serial_irq_dev_oe;
      repeat (c) begin
         @(posedge MCLK);
         #1;
         if (i_bir_if.serial_irq_dev_oe && !p) rises++;
         p = i_bir_if.serial_irq_dev_oe;
      end
   endtask : count_rises
   task finish_test;
      $display("checks %0d errors %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : finish_test

   initial begin
      MCLK = 1'b0;
      forever #5 MCLK = ~MCLK;
   end
   always @(posedge MCLK) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         $display("ERROR %0t run timed out", $time);
         finish_test();
      end
   end

   initial begin
      seed = 32'hd56d;
      {PCI_PERR, PCI_SERR, SERR_NMI_EN, APIC_MODE, SIRQ_CONT} = 5'h00;
      {SERVICER, SLAVE_REQ, PERR_SEEN, RETRY_OK} = 4'h0;
      IRQ_REQ = 16'h0100;
      PCI_INT = 8'h00;
      for (i = 0; i < BIR_NUM_APIC_IN; i++) APIC_MAP[i*BIR_SRC_W +: BIR_SRC_W] = 5'h0F;
      RST_N = 1'b0;
      tick(2);
      RST_N = 1'b1;
      tick(4);
      for (i = 0; i < 16; i++) begin
         r = $random(seed);
         SERVICER = r[0];
         IRQ_REQ = act(i);
         tick(1);
         `BIR_CHK(i_bir_if.legacy_intr, exp_legacy(i), "legacy output")
         tick(1);
         `BIR_CHK(CASCADE_OUT, i >= 8, "cascade output")
         tick(2);
         `BIR_CHK(TAKE_INTR, exp_legacy(i) & SERVICER, "servicer take")
         IRQ_REQ = 16'h0100;
         tick(6);
      end
      for (k = 0; k < 4; k++) begin
         PCI_SERR = k[0];
         SERR_NMI_EN = k[1];
         tick(1);
         `BIR_CHK(i_bir_if.nmi, k == 3, "nmi routing")
         tick(5);
         `BIR_CHK(NMI_SEEN, k == 3, "nmi seen")
      end
      PCI_SERR = 1'b0;
      for (k = 0; k < 2; k++) begin
         PERR_SEEN = 1'b1;
         RETRY_OK = k[0];
         tick(5);
         `BIR_CHK(RETRY, k[0], "parity retry")
         `BIR_CHK(SERR_OUT, !k[0], "parity escalation")
         PERR_SEEN = 1'b0;
         tick(5);
      end
      APIC_MODE = 1'b1;
      tick(2);
      for (n = 0; n < 6; n++) begin
         r = $random(seed);
         pin = (n == 0) ? 0 : (n == 1) ? BIR_NUM_APIC_IN - 1 : $unsigned(r) % BIR_NUM_APIC_IN;
         src = n[0] ? 5'(16 + r[2:0]) : ((r[2:0] == 3'h2) ? 5'h03 : {2'h0, r[2:0]});
         APIC_MAP[pin*BIR_SRC_W +: BIR_SRC_W] = src;
         tick(2);
         if (src >= 5'h10) PCI_INT[src-5'h10] = 1'b1;
         else IRQ_REQ[src] = 1'b1;
         k = 0;
         while (MSG_VALID !== 1'b1 && k < 400) begin
            tick(1);
            k++;
         end
         `BIR_CHK(MSG_VEC, pin[7:0], "apic vector")
         `BIR_CHK(i_bir_if.legacy_intr, 1'b0, "legacy in apic mode")
         PCI_INT = 8'h00;
         IRQ_REQ = 16'h0100;
         APIC_MAP[pin*BIR_SRC_W +: BIR_SRC_W] = 5'h0F;
         tick(200);
         `BIR_CHK(BUSY, 1'b0, "link idle after message")
      end
      APIC_MODE = 1'b0;
      count_rises(300, r);
      `BIR_CHK(r == 0, 1'b1, "quiet frame unasked")
      SLAVE_REQ = 1'b1;
      tick(1);
      SLAVE_REQ = 1'b0;
      count_rises(200, r);
      `BIR_CHK(r > 0, 1'b1, "slave start ignored")
      tick(200);
      SIRQ_CONT = 1'b1;
      count_rises(600, r);
      `BIR_CHK(r >= 4, 1'b1, "continuous frames")
      SIRQ_CONT = 1'b0;
      tick(300);
      count_rises(300, r);
      `BIR_CHK(r == 0, 1'b1, "frames after quiet")
      PCI_SERR = 1'b1;
      SERR_NMI_EN = 1'b1;
      tick(2);
      RST_N = 1'b0;
      #1;
      `BIR_CHK(i_bir_if.nmi, 1'b0, "nmi in reset")
      finish_test();
   end
endmodule : board_interrupt_routing_tb
`undef BIR_CHK
`default_nettype wire
